// ===== dv/mnst_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module mnst_mem_model (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        MEM_REQ,
    input  wire logic [31:0] MEM_ADDR,
    input  wire logic [3:0]  WAIT_CYC,
    output logic             MEM_ACK,
    output logic      [31:0] MEM_RDATA
);
    logic [3:0] cnt;
    // combinational so an ack can land in the cycle the request rises
    assign MEM_ACK = MEM_REQ && cnt == WAIT_CYC;
    // outside the ack the data differs, so a late sample cannot match
    assign MEM_RDATA = MEM_ACK ? ~MEM_ADDR ^ 32'h00a50000 : MEM_ADDR;
    always_ff @(posedge MCLK)
    begin
        cnt <= (RST || !MEM_REQ || MEM_ACK) ? 4'h0 : cnt + 4'h1;
    end
endmodule
`default_nettype wire

// ===== dv/mnst_xfer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mnst_properties #(
    parameter int ADDR_W = 32
) (
    input wire logic              MCLK,
    input wire logic              RST,
    input wire logic              CMD_VALID,
    input wire logic              CMD_READY,
    input wire logic              CMD_MULTI,
    input wire logic [15:0]       CMD_MASK,
    input wire logic              SYS_MODE,
    input wire logic              MEM_REQ,
    input wire logic              MEM_ACK,
    input wire logic [ADDR_W-1:0] MEM_ADDR,
    input wire logic              MEM_NORMAL_TABLES,
    input wire logic              MEM_SYS_RIGHTS,
    input wire logic              DONE,
    input wire logic              PRIV_TRAP
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    wire logic take = CMD_VALID && CMD_READY;
    wire logic empty = take && CMD_MULTI && CMD_MASK == 16'h0000;
    // normal-space command offered from normal mode: must trap, never access
    wire logic user_cmd = take && !CMD_MULTI && !SYS_MODE;
    sequence s_sys_access;
        ##2 MEM_REQ && MEM_NORMAL_TABLES && MEM_SYS_RIGHTS;
    endsequence
    a_user_quiet: assert property (take && !CMD_MULTI && !SYS_MODE |=> !MEM_REQ [*3])
        else $error("access made in normal mode");
    a_sys_path: assert property (take && !CMD_MULTI && SYS_MODE |-> s_sys_access)
        else $error("normal-space access not issued");
    a_multi_busy: assert property (take && CMD_MULTI |=> !CMD_READY [*2])
        else $error("ready during transfer");
    a_empty_quiet: assert property (empty |=> !MEM_REQ [*8])
        else $error("access on empty mask");
    a_empty_done: assert property (empty |-> ##[16:18] DONE)
        else $error("empty mask not done");
    a_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
        else $error("request changed before ack");
    a_req_gap: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
        else $error("request not dropped");
    a_done_pulse: assert property (DONE |=> !DONE)
        else $error("done longer than a cycle");
    a_trap_raise: assert property (user_cmd |=> PRIV_TRAP)
        else $error("no trap for normal-mode command");
    a_trap_cause: assert property (PRIV_TRAP |-> $past(user_cmd))
        else $error("trap without normal-mode command");
endmodule
bind mnst_xfer mnst_properties #(.ADDR_W(ADDR_W)) u_props (.MCLK(MCLK), .RST(RST),
    .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD_MULTI(CMD_MULTI),
    .CMD_MASK(CMD_MASK), .SYS_MODE(SYS_MODE), .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK),
    .MEM_ADDR(MEM_ADDR), .MEM_NORMAL_TABLES(MEM_NORMAL_TABLES),
    .MEM_SYS_RIGHTS(MEM_SYS_RIGHTS), .DONE(DONE), .PRIV_TRAP(PRIV_TRAP));
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
    logic        mclk = 1'b0, rst = 1'b1, valid = 1'b0, multi = 1'b0, to_mem = 1'b0;
    logic        instr = 1'b0, sys = 1'b0, saw_trap;
    logic [1:0]  size = 2'h0;
    logic [4:0]  reg_n = 5'h00;
    logic [15:0] mask = 16'h0000;
    logic [31:0] ea = 32'h0;
    logic [3:0]  wait_cyc = 4'h0;
    wire logic        ready, wr_en, req, mwr, ntab, mins, sysr, ack, done, trap;
    wire logic [4:0]  rd_a, wr_a;
    wire logic [1:0]  wr_sz, msz;
    wire logic [31:0] rd_d, wr_d, maddr, wdat, rdat;
    int          tests_run = 0, fail_count = 0;
    logic [37:0] acc[$];
    logic [31:0] wq[$];
    logic [38:0] rfq[$];
    function automatic logic [31:0] rf_of(input logic [4:0] r);
        return {16'hc0de, 11'h0, r};
    endfunction
    assign rd_d = rf_of(rd_a);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (req && ack)
            acc.push_back({mwr, mins, sysr, ntab, msz, maddr});
        if (req && ack && mwr)
            wq.push_back(wdat);
        if (wr_en)
            rfq.push_back({wr_a, wr_sz, wr_d});
    end
    mnst_xfer DUT (.MCLK(mclk), .RST(rst), .CMD_VALID(valid), .CMD_READY(ready),
        .CMD_MULTI(multi), .CMD_TO_MEM(to_mem), .CMD_INSTR_SPACE(instr), .CMD_SIZE(size),
        .CMD_REG(reg_n), .CMD_MASK(mask), .CMD_EA(ea), .SYS_MODE(sys), .RF_RD_ADDR(rd_a),
        .RF_RD_DATA(rd_d), .RF_WR_EN(wr_en), .RF_WR_ADDR(wr_a), .RF_WR_SIZE(wr_sz),
        .RF_WR_DATA(wr_d), .MEM_REQ(req), .MEM_WRITE(mwr), .MEM_ADDR(maddr), .MEM_SIZE(msz),
        .MEM_WDATA(wdat), .MEM_NORMAL_TABLES(ntab), .MEM_INSTR_SPACE(mins),
        .MEM_SYS_RIGHTS(sysr), .MEM_ACK(ack), .MEM_RDATA(rdat), .DONE(done), .PRIV_TRAP(trap));
    mnst_mem_model u_mem (.MCLK(mclk), .RST(rst), .MEM_REQ(req), .MEM_ADDR(maddr),
        .WAIT_CYC(wait_cyc), .MEM_ACK(ack), .MEM_RDATA(rdat));
    task automatic stop_test;
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic run(input logic m, t, i, s, input logic [1:0] z, input logic [4:0] r,
                       input logic [15:0] k, input logic [31:0] a);
        int n;
        acc.delete();
        wq.delete();
        rfq.delete();
        @(negedge mclk);
        {multi, to_mem, instr, sys, size, reg_n, mask, ea, valid} = {m, t, i, s, z, r, k, a, 1'b1};
        @(negedge mclk);
        valid = 1'b0;
        // the address source moves once the command is taken; accesses must not follow
        ea = ~a;
        for (n = 0; n < 60 && done !== 1'b1 && trap !== 1'b1; n++)
            @(negedge mclk);
        saw_trap = trap;
        // let the final edge's register write reach the monitor
        @(negedge mclk);
        if (n == 60)
        begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic t_multi_load;
        logic [4:0] r [3] = '{5'h10, 5'h00, 5'h0e};
        wait_cyc = 4'h2;
        run(1, 0, 0, 0, 2'h2, 5'h00, 16'h8101, 32'h100);
        `CHK("ld n", 3, acc.size())
        `CHK("rf n", 3, rfq.size())
        foreach (acc[k]) `CHK("ld acc", {6'b000110, 32'h100 + 4 * k}, acc[k])
        foreach (rfq[k]) `CHK("ld rf", {r[k], 2'h2, ~(32'h100 + 4 * k) ^ 32'h00a50000}, rfq[k])
    endtask
    task automatic t_multi_store;
        logic [4:0] r [2] = '{5'h1e, 5'h00};
        wait_cyc = 4'h0;
        // system mode: multi accesses use system tables and rights
        run(1, 1, 0, 1, 2'h2, 5'h00, 16'h0180, 32'h200);
        `CHK("st n", 2, wq.size())
        `CHK("st rf", 0, rfq.size())
        `CHK("st trap", 1'b0, saw_trap)
        foreach (acc[k]) `CHK("st acc", {6'b101010, 32'h200 + 4 * k}, acc[k])
        foreach (wq[k]) `CHK("st data", rf_of(r[k]), wq[k])
    endtask
    task automatic t_empty;
        run(1, 0, 0, 0, 2'h2, 5'h00, 16'h0000, 32'h300);
        `CHK("empty", 0, acc.size() + rfq.size())
    endtask
    task automatic t_normal;
        for (int c = 0; c < 12; c++)
        begin
            run(1'b0, c[0], c[1], 1'b1, 2'(c / 4), 5'h07, 16'h0000, 32'h400 + c);
            `CHK("n acc", {c[0], c[1], 2'b11, 2'(c / 4), 32'h400 + c}, acc[0])
            `CHK("n trap", 1'b0, saw_trap)
            if (c[0])
                `CHK("n st", rf_of(5'h07), wq[0])
            else
                `CHK("n ld", {5'h07, 2'(c / 4), ~(32'h400 + c) ^ 32'h00a50000}, rfq[0])
        end
    endtask
    task automatic t_trap;
        run(0, 1, 0, 0, 2'h1, 5'h03, 16'h0000, 32'h500);
        `CHK("trap", 1'b1, saw_trap)
        `CHK("trap acc", 0, acc.size() + rfq.size())
    endtask
    initial
    begin
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        t_multi_load();
        t_multi_store();
        t_empty();
        t_normal();
        t_trap();
        stop_test();
    end
endmodule
`default_nettype wire

// ===== logic/mnst_cfg.svh
`ifndef MNST_CFG_SVH
`define MNST_CFG_SVH

// operand size codes on CMD_SIZE, MEM_SIZE and RF_WR_SIZE
`define MNST_SIZE_BYTE     2'h0
`define MNST_SIZE_WORD     2'h1
`define MNST_SIZE_LONG     2'h2

// address advance per transferred longword register
`define MNST_ADDR_STEP     4

// mask layout: low byte selects the upper register bank, high byte the lower bank
`define MNST_MASK_BITS     16
`define MNST_LAST_BIT      4'hf
`define MNST_HI_BANK_BIT   3

// reset values
`define MNST_RST_MASK      16'h0000
`define MNST_RST_IDX       4'h0
`define MNST_RST_REG       5'h00

`endif

// ===== logic/mnst_pkg.sv
`default_nettype none

package mnst_pkg;

    typedef enum logic [2:0] {
        MNST_IDLE = 3'b001,
        MNST_SCAN = 3'b010,
        MNST_MEM  = 3'b100
    } mnst_state_e;

    typedef logic [1:0] mnst_size_t;

endpackage

`default_nettype wire

// ===== logic/mnst_xfer.sv
// Summary of operation
// - multi-longword transfer, direction from opcode variant
// - set mask bits transfer; clear bits skipped
// - mask bits 0-7 select registers 16..30
// - mask bits 8-15 select registers 0..14
// - address latched once, plus four per transfer
// - base register never written by increments
// - base overwrite mid-load does not change addresses
// - system mode may access normal-mode spaces
// - data variants data space, single-register instruction variants instruction; multi transfers always data space
// - load and store, byte word longword sizes
// - single transfers: normal tables, system rights; multi transfers use the current mode's tables and rights
`timescale 1ns/1ps
`default_nettype none
`include "mnst_cfg.svh"

module mnst_xfer #(
    parameter int ADDR_W = 32,
    parameter int DATA_W = 32
) (
    input  wire logic                 MCLK,
    input  wire logic                 RST,
    input  wire logic                 CMD_VALID,
    output logic                      CMD_READY,
    input  wire logic                 CMD_MULTI,
    input  wire logic                 CMD_TO_MEM,
    input  wire logic                 CMD_INSTR_SPACE,
    input  wire logic [1:0]           CMD_SIZE,
    input  wire logic [4:0]           CMD_REG,
    input  wire logic [15:0]          CMD_MASK,
    input  wire logic [ADDR_W-1:0]    CMD_EA,
    input  wire logic                 SYS_MODE,
    output logic      [4:0]           RF_RD_ADDR,
    input  wire logic [DATA_W-1:0]    RF_RD_DATA,
    output logic                      RF_WR_EN,
    output logic      [4:0]           RF_WR_ADDR,
    output logic      [1:0]           RF_WR_SIZE,
    output logic      [DATA_W-1:0]    RF_WR_DATA,
    output logic                      MEM_REQ,
    output logic                      MEM_WRITE,
    output logic      [ADDR_W-1:0]    MEM_ADDR,
    output logic      [1:0]           MEM_SIZE,
    output logic      [DATA_W-1:0]    MEM_WDATA,
    output logic                      MEM_NORMAL_TABLES,
    output logic                      MEM_INSTR_SPACE,
    output logic                      MEM_SYS_RIGHTS,
    input  wire logic                 MEM_ACK,
    input  wire logic [DATA_W-1:0]    MEM_RDATA,
    output logic                      DONE,
    output logic                      PRIV_TRAP
);

    generate
        if (DATA_W != 32 || ADDR_W < 8 || ADDR_W > 64)
        begin : g_bad_width
            $error("mnst_xfer: DATA_W must be 32 and ADDR_W 8..64");
        end
    endgenerate

    typedef struct packed {
        mnst_pkg::mnst_state_e st;
        logic [15:0]           mask;
        logic [ADDR_W-1:0]     addr;
        logic [3:0]            idx;
        logic                  multi;
        logic                  to_mem;
        logic                  instr_sp;
        logic                  sys;
        mnst_pkg::mnst_size_t  size;
        logic [4:0]            rd_addr;
        logic                  mem_req;
        logic [DATA_W-1:0]     wdata;
        logic                  rf_we;
        logic [4:0]            wr_reg;
        logic [DATA_W-1:0]     rf_wdata;
        logic                  done;
        logic                  trap;
    } mnst_regs_s;

    mnst_regs_s s;
    mnst_regs_s next_s;

    localparam logic [ADDR_W-1:0] STEP = ADDR_W'(`MNST_ADDR_STEP);

    // mask bit to longword register number: bits 0-7 -> 16..30, bits 8-15 -> 0..14
    function automatic logic [4:0] mnst_map(input logic [3:0] bit_no);
        mnst_map = {~bit_no[`MNST_HI_BANK_BIT], bit_no[2:0], 1'b0};
    endfunction

    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.trap = 1'b0;
        next_s.rf_we = 1'b0;
        case (s.st)
            mnst_pkg::MNST_IDLE:
            begin
                if (CMD_VALID)
                begin
                    if (!CMD_MULTI && !SYS_MODE)
                    begin
                        // command is consumed without any access
                        next_s.trap = 1'b1;
                    end
                    else
                    begin
                        // private copy of the address: no register write can disturb it
                        next_s.addr = CMD_EA;
                        next_s.multi = CMD_MULTI;
                        next_s.to_mem = CMD_TO_MEM;
                        next_s.instr_sp = CMD_INSTR_SPACE & ~CMD_MULTI;
                        next_s.sys = SYS_MODE;
                        next_s.mask = CMD_MASK;
                        next_s.idx = `MNST_RST_IDX;
                        if (CMD_MULTI)
                        begin
                            next_s.size = `MNST_SIZE_LONG;
                            next_s.rd_addr = mnst_map(`MNST_RST_IDX);
                        end
                        else
                        begin
                            next_s.size = CMD_SIZE;
                            next_s.rd_addr = CMD_REG;
                        end
                        next_s.st = mnst_pkg::MNST_SCAN;
                    end
                end
            end
            mnst_pkg::MNST_SCAN:
            begin
                if (!s.multi || s.mask[s.idx])
                begin
                    // store data is sampled here, one cycle after the read address settled
                    next_s.wdata = RF_RD_DATA;
                    next_s.mem_req = 1'b1;
                    next_s.st = mnst_pkg::MNST_MEM;
                end
                else if (s.idx == `MNST_LAST_BIT)
                begin
                    next_s.done = 1'b1;
                    next_s.st = mnst_pkg::MNST_IDLE;
                end
                else
                begin
                    // clear bit: no memory slot, address unchanged
                    next_s.idx = s.idx + 4'h1;
                    next_s.rd_addr = mnst_map(s.idx + 4'h1);
                end
            end
            mnst_pkg::MNST_MEM:
            begin
                if (MEM_ACK)
                begin
                    next_s.mem_req = 1'b0;
                    if (!s.to_mem)
                    begin
                        next_s.rf_we = 1'b1;
                        next_s.wr_reg = s.rd_addr;
                        next_s.rf_wdata = MEM_RDATA;
                    end
                    next_s.addr = s.addr + STEP;
                    if (!s.multi || s.idx == `MNST_LAST_BIT)
                    begin
                        next_s.done = 1'b1;
                        next_s.st = mnst_pkg::MNST_IDLE;
                    end
                    else
                    begin
                        next_s.idx = s.idx + 4'h1;
                        next_s.rd_addr = mnst_map(s.idx + 4'h1);
                        next_s.st = mnst_pkg::MNST_SCAN;
                    end
                end
            end
            default:
            begin
                next_s.st = mnst_pkg::MNST_IDLE;
                next_s.mem_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            s.st <= mnst_pkg::MNST_IDLE;
            s.mask <= `MNST_RST_MASK;
            s.addr <= '0;
            s.idx <= `MNST_RST_IDX;
            s.multi <= 1'b0;
            s.to_mem <= 1'b0;
            s.instr_sp <= 1'b0;
            s.sys <= 1'b0;
            s.size <= `MNST_SIZE_LONG;
            s.rd_addr <= `MNST_RST_REG;
            s.mem_req <= 1'b0;
            s.wdata <= '0;
            s.rf_we <= 1'b0;
            s.wr_reg <= `MNST_RST_REG;
            s.rf_wdata <= '0;
            s.done <= 1'b0;
            s.trap <= 1'b0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign CMD_READY = (s.st == mnst_pkg::MNST_IDLE);
    assign RF_RD_ADDR = s.rd_addr;
    assign RF_WR_EN = s.rf_we;
    assign RF_WR_ADDR = s.wr_reg;
    assign RF_WR_SIZE = s.size;
    assign RF_WR_DATA = s.rf_wdata;
    assign MEM_REQ = s.mem_req;
    assign MEM_WRITE = s.to_mem;
    assign MEM_ADDR = s.addr;
    assign MEM_SIZE = s.size;
    assign MEM_WDATA = s.wdata;
    // normal-space access: normal tables for translation, system rights for protection
    assign MEM_NORMAL_TABLES = ~s.multi | ~s.sys;
    assign MEM_INSTR_SPACE = s.instr_sp;
    assign MEM_SYS_RIGHTS = s.sys;
    assign DONE = s.done;
    assign PRIV_TRAP = s.trap;

endmodule

`default_nettype wire
